// file: rtl/asb_regs.svh
// Constants for the shift, add and branch execution datapath
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH

// ----------------------------------------
// Flag register bit positions
// ----------------------------------------
`define ASB_V_BIT 7
`define ASB_H_BIT 4
`define ASB_I_BIT 3
`define ASB_N_BIT 2
`define ASB_Z_BIT 1
`define ASB_C_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ASB_ACC_RST 8'h00
`define ASB_HX_RST 16'h0000
`define ASB_SP_RST 16'h00ff
`define ASB_PC_RST 16'h0000
`define ASB_CCR_RST 8'h68

// ----------------------------------------
// Opcodes and opcode fields
// ----------------------------------------
`define ASB_PREFIX 8'h9e
`define ASB_OP_AIS 8'ha7
`define ASB_OP_AIX 8'haf
`define ASB_OP_BCC 8'h24
`define ASB_OP_BCS 8'h25
`define ASB_LO_ADC 4'h9
`define ASB_LO_ADD 4'hb
`define ASB_LO_AND 4'h4
`define ASB_LO_ASL 4'h8
`define ASB_LO_ASR 4'h7
`define ASB_HI_MEMORY_BIT_RESET_OP 4'h1

// ----------------------------------------
// Cycle counts per addressing mode
// ----------------------------------------
`define ASB_CYC_IMM 3'd2
`define ASB_CYC_DIR 3'd3
`define ASB_CYC_EXT 3'd4
`define ASB_CYC_IX2 3'd4
`define ASB_CYC_IX1 3'd3
`define ASB_CYC_IX 3'd2
`define ASB_CYC_SP2 3'd5
`define ASB_CYC_SP1 3'd4
`define ASB_CYC_INH 3'd1
`define ASB_CYC_REL 3'd3

// ----------------------------------------
// Instruction lengths in bytes, prefix excluded
// ----------------------------------------
`define ASB_LEN_1 3'd1
`define ASB_LEN_2 3'd2
`define ASB_LEN_3 3'd3
`define ASB_BRANCH_STEP 16'h0002

`endif

// file: rtl/asb_pkg.sv
// Types for the shift, add and branch execution datapath
package asb_pkg;

	typedef enum logic [3:0] {
		kind_ill, kind_adc, kind_add, kind_and, kind_ais, kind_aix,
		kind_asl, kind_asr, kind_bcc, kind_bcs, kind_memory_bit_reset_op
	} asb_kind_t;

	typedef enum logic [3:0] {
		mode_imm, mode_dir, mode_ext, mode_ix2, mode_ix1, mode_ix,
		mode_sp2, mode_sp1, mode_inh_a, mode_inh_x, mode_rel
	} asb_mode_t;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_read = 3'b010,
		st_pad = 3'b100
	} asb_st_t;

	typedef struct packed {
		asb_kind_t kind;
		asb_mode_t mode;
		logic [2:0] len;
		logic [2:0] cyc;
		logic rmw;
		logic mem;
	} asb_dec_t;

	typedef struct packed {
		asb_st_t st;
		logic [7:0] acc;
		logic [15:0] hx;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [7:0] flag_register;
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic ready;
		logic done;
		logic illegal;
		logic [2:0] cnt;
		asb_kind_t kind;
		asb_mode_t mode;
		logic [2:0] bitn;
	} asb_state_t;

endpackage : asb_pkg

// file: rtl/asb_alu_if.sv
// Operand and result bundle between core and flag ALU
`timescale 1ns/10ps
interface asb_alu_if;
	asb_pkg::asb_kind_t kind;
	logic [7:0] a;
	logic [7:0] b;
	logic [7:0] ccr_in;
	logic [7:0] res;
	logic [7:0] ccr_out;
	modport core (output kind, a, b, ccr_in, input res, ccr_out);
	modport alu (input kind, a, b, ccr_in, output res, ccr_out);
endinterface : asb_alu_if

// file: rtl/asb_alu.sv
// Eight-bit add, AND and arithmetic shift unit with flag update
`timescale 1ns/10ps
`include "asb_regs.svh"
module asb_alu (
	asb_alu_if.alu bus
);

	// ----------------------------------------
	// Result and flags
	// ----------------------------------------
	// Flags not touched by an operation pass through unchanged
	always_comb begin
		logic [8:0] sum;
		logic [4:0] low;
		logic cin;
		logic [7:0] r;
		logic [7:0] f;
		logic upd;
		cin = (bus.kind == asb_pkg::kind_adc) ? bus.ccr_in[`ASB_C_BIT] : 1'b0;
		sum = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin};
		low = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, cin};
		r = bus.a;
		f = bus.ccr_in;
		upd = 1'b1;
		case (bus.kind)
			asb_pkg::kind_adc, asb_pkg::kind_add: begin
				r = sum[7:0];
				f[`ASB_H_BIT] = low[4];
				f[`ASB_V_BIT] = (bus.a[7] & bus.b[7] & ~r[7]) |
					(~bus.a[7] & ~bus.b[7] & r[7]);
				f[`ASB_C_BIT] = sum[8];
			end
			asb_pkg::kind_and: begin
				r = bus.a & bus.b;
				f[`ASB_V_BIT] = 1'b0;
			end
			asb_pkg::kind_asl: begin
				r = {bus.a[6:0], 1'b0};
				f[`ASB_C_BIT] = bus.a[7];
				f[`ASB_V_BIT] = r[7] ^ bus.a[7];
			end
			asb_pkg::kind_asr: begin
				r = {bus.a[7], bus.a[7:1]};
				f[`ASB_C_BIT] = bus.a[0];
				f[`ASB_V_BIT] = r[7] ^ bus.a[0];
			end
			default: begin
				upd = 1'b0;
			end
		endcase
		if (upd) begin
			f[`ASB_N_BIT] = r[7];
			f[`ASB_Z_BIT] = (r == 8'h00);
		end
		bus.res = r;
		bus.ccr_out = f;
	end

endmodule : asb_alu

// file: rtl/asb_core.sv
// Execution datapath for add, AND, shifts, stack/index adjust, branches
`timescale 1ns/10ps
`include "asb_regs.svh"
// What this block does
// - Add with carry into accumulator
// - Add without carry into accumulator
// - Half carry from bit three
// - Overflow on same-sign operands, flipped result
// - Carry out of bit seven
// - Negative copies bit seven, zero on zero
// - Stack pointer plus signed literal, flags kept
// - Index pair plus signed literal, flags kept
// - AND into accumulator, overflow cleared
// - Shift left, zero in, carry from top
// - Shift overflow equals negative xor carry
// - Left shift opcodes and cycle counts
// - Shift right keeps sign, carry from bottom
// - Right shift opcodes and cycle counts
// - Branch when carry clear, flags kept
// - Branch when carry set, flags kept
// - Clear one bit by read-modify-write
// - Bit clear opcodes eleven to 1f
// - Zero page high address byte is zero
// - Prefix selects stack-relative indexed form
// - Branch offset signed from next instruction
module asb_core (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic valid_in,
	input wire logic prefix_in,
	input wire logic [7:0] opcode_in,
	input wire logic [7:0] opr_hi_in,
	input wire logic [7:0] opr_lo_in,
	input wire logic [7:0] mem_rdata_in,
	output logic ready_out,
	output logic done_out,
	output logic illegal_out,
	output logic [7:0] acc_out,
	output logic [15:0] hx_out,
	output logic [15:0] sp_out,
	output logic [15:0] pc_out,
	output logic [7:0] flags_out,
	output logic [15:0] mem_addr_out,
	output logic mem_rd_out,
	output logic mem_wr_out,
	output logic [7:0] mem_wdata_out
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [15:0] asb_sext(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction : asb_sext

	// Indexed column of the opcode map, prefix moves it onto the stack
	function automatic asb_pkg::asb_mode_t asb_col_mode(
		input logic pre,
		input logic [3:0] hi
	);
		case (hi)
			4'ha: return asb_pkg::mode_imm;
			4'hb: return asb_pkg::mode_dir;
			4'hc: return asb_pkg::mode_ext;
			4'hd: return pre ? asb_pkg::mode_sp2 : asb_pkg::mode_ix2;
			4'he: return pre ? asb_pkg::mode_sp1 : asb_pkg::mode_ix1;
			default: return asb_pkg::mode_ix;
		endcase
	endfunction : asb_col_mode

	// Opcode decode, cycles and byte length
	function automatic asb_pkg::asb_dec_t asb_decode(
		input logic pre,
		input logic [7:0] op
	);
		asb_pkg::asb_dec_t d;
		logic alu_lo;
		d.kind = asb_pkg::kind_ill;
		d.mode = asb_pkg::mode_imm;
		d.rmw = 1'b0;
		alu_lo = (op[3:0] == `ASB_LO_ADC) || (op[3:0] == `ASB_LO_ADD) ||
			(op[3:0] == `ASB_LO_AND);
		if (alu_lo && (op[7:4] >= 4'ha) &&
			(!pre || op[7:4] == 4'hd || op[7:4] == 4'he)) begin
			d.mode = asb_col_mode(pre, op[7:4]);
			if (op[3:0] == `ASB_LO_ADC) begin
				d.kind = asb_pkg::kind_adc;
			end else if (op[3:0] == `ASB_LO_ADD) begin
				d.kind = asb_pkg::kind_add;
			end else begin
				d.kind = asb_pkg::kind_and;
			end
		end else if ((op[3:0] == `ASB_LO_ASL || op[3:0] == `ASB_LO_ASR) &&
			op[7:4] >= 4'h3 && op[7:4] <= 4'h7 &&
			(!pre || op[7:4] == 4'h6)) begin
			d.kind = (op[3:0] == `ASB_LO_ASL) ? asb_pkg::kind_asl :
				asb_pkg::kind_asr;
			d.rmw = (op[7:4] != 4'h4) && (op[7:4] != 4'h5);
			case (op[7:4])
				4'h3: d.mode = asb_pkg::mode_dir;
				4'h4: d.mode = asb_pkg::mode_inh_a;
				4'h5: d.mode = asb_pkg::mode_inh_x;
				4'h6: d.mode = pre ? asb_pkg::mode_sp1 : asb_pkg::mode_ix1;
				default: d.mode = asb_pkg::mode_ix;
			endcase
		end else if (!pre && op == `ASB_OP_AIS) begin
			d.kind = asb_pkg::kind_ais;
		end else if (!pre && op == `ASB_OP_AIX) begin
			d.kind = asb_pkg::kind_aix;
		end else if (!pre && (op == `ASB_OP_BCC || op == `ASB_OP_BCS)) begin
			d.kind = (op == `ASB_OP_BCC) ? asb_pkg::kind_bcc :
				asb_pkg::kind_bcs;
			d.mode = asb_pkg::mode_rel;
		end else if (!pre && op[7:4] == `ASB_HI_MEMORY_BIT_RESET_OP && op[0]) begin
			d.kind = asb_pkg::kind_memory_bit_reset_op;
			d.mode = asb_pkg::mode_dir;
			d.rmw = 1'b1;
		end
		case (d.mode)
			asb_pkg::mode_imm: begin
				d.cyc = `ASB_CYC_IMM;
				d.len = `ASB_LEN_2;
			end
			asb_pkg::mode_dir: begin
				d.cyc = `ASB_CYC_DIR;
				d.len = `ASB_LEN_2;
			end
			asb_pkg::mode_ext: begin
				d.cyc = `ASB_CYC_EXT;
				d.len = `ASB_LEN_3;
			end
			asb_pkg::mode_ix2: begin
				d.cyc = `ASB_CYC_IX2;
				d.len = `ASB_LEN_3;
			end
			asb_pkg::mode_ix1: begin
				d.cyc = `ASB_CYC_IX1;
				d.len = `ASB_LEN_2;
			end
			asb_pkg::mode_sp2: begin
				d.cyc = `ASB_CYC_SP2;
				d.len = `ASB_LEN_3;
			end
			asb_pkg::mode_sp1: begin
				d.cyc = `ASB_CYC_SP1;
				d.len = `ASB_LEN_2;
			end
			asb_pkg::mode_rel: begin
				d.cyc = `ASB_CYC_REL;
				d.len = `ASB_LEN_2;
			end
			asb_pkg::mode_inh_a, asb_pkg::mode_inh_x: begin
				d.cyc = `ASB_CYC_INH;
				d.len = `ASB_LEN_1;
			end
			default: begin
				d.cyc = `ASB_CYC_IX;
				d.len = `ASB_LEN_1;
			end
		endcase
		// Memory read-modify-write costs one extra bus cycle
		d.cyc = d.cyc + {2'b00, d.rmw};
		d.len = d.len + {2'b00, pre};
		d.mem = !(d.mode inside {asb_pkg::mode_imm, asb_pkg::mode_rel,
			asb_pkg::mode_inh_a, asb_pkg::mode_inh_x});
		return d;
	endfunction : asb_decode

	// Effective address of the memory operand
	function automatic logic [15:0] asb_ea(
		input asb_pkg::asb_mode_t m,
		input logic [15:0] hx,
		input logic [15:0] sp,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		case (m)
			asb_pkg::mode_dir: return {8'h00, lo};
			asb_pkg::mode_ext: return {hi, lo};
			asb_pkg::mode_ix2: return hx + {hi, lo};
			asb_pkg::mode_ix1: return hx + {8'h00, lo};
			asb_pkg::mode_sp2: return sp + {hi, lo};
			asb_pkg::mode_sp1: return sp + {8'h00, lo};
			default: return hx;
		endcase
	endfunction : asb_ea

	// ----------------------------------------
	// State, decode and ALU
	// ----------------------------------------
	localparam asb_pkg::asb_state_t ASB_RST = '{
		st: asb_pkg::st_idle, acc: `ASB_ACC_RST, hx: `ASB_HX_RST,
		sp: `ASB_SP_RST, pc: `ASB_PC_RST, flag_register: `ASB_CCR_RST,
		addr: 16'h0000, rd: 1'b0, wr: 1'b0, wdata: 8'h00, ready: 1'b1,
		done: 1'b0, illegal: 1'b0, cnt: 3'd0, kind: asb_pkg::kind_ill,
		mode: asb_pkg::mode_imm, bitn: 3'd0};

	asb_pkg::asb_state_t s_reg;
	asb_pkg::asb_state_t s_next;
	asb_pkg::asb_dec_t dec;
	logic go;
	logic shift_k;
	asb_alu_if alu_bus ();

	asb_alu u_alu (
		.bus(alu_bus)
	);

	assign dec = asb_decode(prefix_in, opcode_in);
	assign go = s_reg.ready && valid_in && (dec.kind != asb_pkg::kind_ill);
	// Taken from the kind sources, not the bundle, to avoid a comb loop
	assign shift_k = s_reg.ready ?
		(dec.kind == asb_pkg::kind_asl || dec.kind == asb_pkg::kind_asr) :
		(s_reg.kind == asb_pkg::kind_asl ||
		s_reg.kind == asb_pkg::kind_asr);

	// Operand steering: issue cycle uses literal or register, read cycle
	// uses the byte the bus returns in that same cycle
	always_comb begin
		alu_bus.kind = s_reg.ready ? dec.kind : s_reg.kind;
		alu_bus.ccr_in = s_reg.flag_register;
		alu_bus.b = s_reg.ready ? opr_lo_in : mem_rdata_in;
		alu_bus.a = s_reg.acc;
		if (shift_k) begin
			if (!s_reg.ready) begin
				alu_bus.a = mem_rdata_in;
			end else if (dec.mode == asb_pkg::mode_inh_x) begin
				alu_bus.a = s_reg.hx[7:0];
			end
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.rd = 1'b0;
		s_next.wr = 1'b0;
		s_next.illegal = 1'b0;
		unique case (s_reg.st)
			asb_pkg::st_idle: begin
				if (valid_in && dec.kind == asb_pkg::kind_ill) begin
					s_next.illegal = 1'b1;
				end else if (valid_in) begin
					s_next.kind = dec.kind;
					s_next.mode = dec.mode;
					s_next.bitn = opcode_in[3:1];
					s_next.cnt = dec.cyc - 3'd1;
					// Fall-through address; taken branches overwrite it
					s_next.pc = s_reg.pc + {13'h0000, dec.len};
					case (dec.kind)
						asb_pkg::kind_ais: begin
							s_next.sp = s_reg.sp + asb_sext(opr_lo_in);
						end
						asb_pkg::kind_aix: begin
							s_next.hx = s_reg.hx + asb_sext(opr_lo_in);
						end
						asb_pkg::kind_bcc, asb_pkg::kind_bcs: begin
							if (s_reg.flag_register[`ASB_C_BIT] ==
								(dec.kind == asb_pkg::kind_bcs)) begin
								s_next.pc = s_reg.pc + `ASB_BRANCH_STEP +
									asb_sext(opr_lo_in);
							end
						end
						default: begin
							if (dec.mem) begin
								s_next.addr = asb_ea(dec.mode, s_reg.hx, s_reg.sp,
									opr_hi_in, opr_lo_in);
								s_next.rd = 1'b1;
							end else begin
								if (dec.mode == asb_pkg::mode_inh_x) begin
									s_next.hx[7:0] = alu_bus.res;
								end else begin
									s_next.acc = alu_bus.res;
								end
								s_next.flag_register = alu_bus.ccr_out;
							end
						end
					endcase
					s_next.done = (dec.cyc == 3'd1);
					s_next.ready = (dec.cyc == 3'd1);
					if (dec.mem) begin
						s_next.st = asb_pkg::st_read;
					end else if (dec.cyc != 3'd1) begin
						s_next.st = asb_pkg::st_pad;
					end
				end
			end
			asb_pkg::st_read: begin
				if (s_reg.kind == asb_pkg::kind_memory_bit_reset_op) begin
					// Flags left alone; only the selected bit drops
					s_next.wr = 1'b1;
					s_next.wdata = mem_rdata_in & ~(8'h01 << s_reg.bitn);
				end else if (s_reg.kind == asb_pkg::kind_asl ||
					s_reg.kind == asb_pkg::kind_asr) begin
					s_next.wr = 1'b1;
					s_next.wdata = alu_bus.res;
					s_next.flag_register = alu_bus.ccr_out;
				end else begin
					s_next.acc = alu_bus.res;
					s_next.flag_register = alu_bus.ccr_out;
				end
			end
			asb_pkg::st_pad: begin
				s_next.cnt = s_reg.cnt;
			end
			default: begin
				s_next = ASB_RST;
			end
		endcase
		// Cycle counter paces every instruction to its documented length
		if (s_reg.st == asb_pkg::st_read || s_reg.st == asb_pkg::st_pad) begin
			s_next.cnt = s_reg.cnt - 3'd1;
			if (s_reg.cnt == 3'd1) begin
				s_next.done = 1'b1;
				s_next.ready = 1'b1;
				s_next.st = asb_pkg::st_idle;
			end else begin
				s_next.st = asb_pkg::st_pad;
			end
		end
		// Interrupt mask is never changed by this datapath
		s_next.flag_register[`ASB_I_BIT] = s_reg.flag_register[`ASB_I_BIT];
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_reg <= ASB_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the state register
	assign ready_out = s_reg.ready;
	assign done_out = s_reg.done;
	assign illegal_out = s_reg.illegal;
	assign acc_out = s_reg.acc;
	assign hx_out = s_reg.hx;
	assign sp_out = s_reg.sp;
	assign pc_out = s_reg.pc;
	assign flags_out = s_reg.flag_register;
	assign mem_addr_out = s_reg.addr;
	assign mem_rd_out = s_reg.rd;
	assign mem_wr_out = s_reg.wr;
	assign mem_wdata_out = s_reg.wdata;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	logic [8:0] chk_sum;
	logic [4:0] chk_nib;
	logic imm_add;
	assign imm_add = go && dec.mode == asb_pkg::mode_imm &&
		(dec.kind == asb_pkg::kind_adc || dec.kind == asb_pkg::kind_add);
	assign chk_sum = {1'b0, acc_out} + {1'b0, opr_lo_in} +
		{8'h00, dec.kind == asb_pkg::kind_adc && flags_out[`ASB_C_BIT]};
	assign chk_nib = {1'b0, acc_out[3:0]} + {1'b0, opr_lo_in[3:0]} +
		{4'h0, dec.kind == asb_pkg::kind_adc && flags_out[`ASB_C_BIT]};

	sequence seq_rmw3;
		mem_rd_out ##1 mem_wr_out ##1 done_out;
	endsequence

	sequence seq_rmw4;
		mem_rd_out ##1 mem_wr_out ##1 !done_out ##1 done_out;
	endsequence

	add_sum_a: assert property (imm_add |=>
		acc_out == $past(chk_sum[7:0]) &&
		flags_out[`ASB_C_BIT] == $past(chk_sum[8]) ##1 done_out)
		else $error("add result or carry wrong");
	half_carry_a: assert property (imm_add |=>
		flags_out[`ASB_H_BIT] == $past(chk_nib[4]))
		else $error("half carry wrong");
	add_ovf_a: assert property (imm_add |=> flags_out[`ASB_V_BIT] ==
		($past(acc_out[7]) == $past(opr_lo_in[7]) &&
		acc_out[7] != $past(acc_out[7])))
		else $error("add overflow wrong");
	and_flags_a: assert property (go && dec.kind == asb_pkg::kind_and &&
		dec.mode == asb_pkg::mode_imm |=> acc_out ==
		($past(acc_out) & $past(opr_lo_in)) && !flags_out[`ASB_V_BIT] &&
		flags_out[`ASB_Z_BIT] == (acc_out == 8'h00) &&
		flags_out[`ASB_N_BIT] == acc_out[7])
		else $error("and result or flags wrong");
	adjust_sp_a: assert property (go && dec.kind == asb_pkg::kind_ais
		|=> sp_out == $past(sp_out) + asb_sext($past(opr_lo_in)) &&
		flags_out == $past(flags_out) ##1 done_out)
		else $error("stack adjust wrong");
	adjust_hx_a: assert property (go && dec.kind == asb_pkg::kind_aix
		|=> hx_out == $past(hx_out) + asb_sext($past(opr_lo_in)) &&
		$stable(flags_out))
		else $error("index adjust wrong");
	shift_left_a: assert property (go && dec.kind == asb_pkg::kind_asl &&
		dec.mode == asb_pkg::mode_inh_a |=> done_out &&
		acc_out == {$past(acc_out[6:0]), 1'b0} &&
		flags_out[`ASB_C_BIT] == $past(acc_out[7]) &&
		flags_out[`ASB_V_BIT] == (acc_out[7] ^ flags_out[`ASB_C_BIT]))
		else $error("left shift wrong");
	shift_right_a: assert property (go && dec.kind == asb_pkg::kind_asr &&
		dec.mode == asb_pkg::mode_inh_a |=> done_out &&
		acc_out == {$past(acc_out[7]), $past(acc_out[7:1])} &&
		flags_out[`ASB_C_BIT] == $past(acc_out[0]) &&
		flags_out[`ASB_V_BIT] == (acc_out[7] ^ flags_out[`ASB_C_BIT]))
		else $error("right shift wrong");
	shift_mem_a: assert property (go && (dec.kind == asb_pkg::kind_asl ||
		dec.kind == asb_pkg::kind_asr) && dec.mode == asb_pkg::mode_ix
		|=> seq_rmw3)
		else $error("indexed shift timing wrong");
	bit_clear_a: assert property (go && dec.kind == asb_pkg::kind_memory_bit_reset_op
		|=> (mem_addr_out[15:8] == 8'h00) and seq_rmw4 and
		(##1 mem_wdata_out == ($past(mem_rdata_in) & ~(8'h01 << s_reg.bitn))
		&& $stable(flags_out)))
		else $error("bit clear wrong");
	branch_pc_a: assert property (go && (dec.kind == asb_pkg::kind_bcc ||
		dec.kind == asb_pkg::kind_bcs) |=> pc_out == $past(pc_out) +
		`ASB_BRANCH_STEP + ($past(flags_out[`ASB_C_BIT] ==
		(dec.kind == asb_pkg::kind_bcs)) ? asb_sext($past(opr_lo_in)) :
		16'h0000) && $stable(flags_out) ##1 !done_out ##1 done_out)
		else $error("branch target or timing wrong");
	stack_rel_a: assert property (go && prefix_in &&
		dec.mode == asb_pkg::mode_sp1 |=> mem_rd_out &&
		mem_addr_out == $past(sp_out) + {8'h00, $past(opr_lo_in)})
		else $error("stack relative address wrong");
	int_mask_a: assert property (##1 $stable(flags_out[`ASB_I_BIT]))
		else $error("interrupt mask changed");

endmodule : asb_core

// file: verif/asb_mem_model.sv
// Zero-page memory model standing behind the datapath bus
`timescale 1ns/10ps
module asb_mem_model (
	input wire logic clk_in,
	input wire logic [15:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg = 8'h00;

	// ----------------------------------------
	// Read and write
	// ----------------------------------------
	// Zero-wait read; an idle bus shows the inverse of the last byte,
	// so a late sample never matches by luck
	assign rdata_out = rd_in ? mem[addr_in[7:0]] : ~last_reg;

	// Writes taken in any cycle, so the write-back always lands
	always @(posedge clk_in) begin
		if (rd_in) begin
			last_reg <= mem[addr_in[7:0]];
		end
		if (wr_in) begin
			mem[addr_in[7:0]] <= wdata_in;
		end
	end
endmodule : asb_mem_model

// file: verif/test_alu_shift_branch_subset.sv
// Self-checking bench for the add, shift and branch datapath
`timescale 1ns/10ps
module test_alu_shift_branch_subset;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic valid_in = 1'b0;
	logic prefix_in = 1'b0;
	logic [7:0] opcode_in = 8'h00;
	logic [7:0] opr_hi_in = 8'h00;
	logic [7:0] opr_lo_in = 8'h00;
	logic [7:0] mem_rdata_in, acc_out, flags_out, mem_wdata_out, f_b;
	logic [15:0] hx_out, sp_out, pc_out, mem_addr_out, pc_b;
	logic ready_out, done_out, illegal_out, mem_rd_out, mem_wr_out;
	logic [15:0] wr_addr = 16'hffff;
	logic [7:0] wr_data = 8'h00;
	int error_cnt = 0;
	int compares = 0;

	// ----------------------------------------
	// Clock, design and memory
	// ----------------------------------------
	// Half period of 4 ns gives 125 MHz
	always #4 clk_in = ~clk_in;

	asb_core i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.valid_in(valid_in), .prefix_in(prefix_in), .opcode_in(opcode_in),
		.opr_hi_in(opr_hi_in), .opr_lo_in(opr_lo_in),
		.mem_rdata_in(mem_rdata_in), .ready_out(ready_out),
		.done_out(done_out), .illegal_out(illegal_out), .acc_out(acc_out),
		.hx_out(hx_out), .sp_out(sp_out), .pc_out(pc_out),
		.flags_out(flags_out), .mem_addr_out(mem_addr_out),
		.mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
		.mem_wdata_out(mem_wdata_out));

	asb_mem_model i_mem (.clk_in(clk_in), .addr_in(mem_addr_out),
		.rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
		.rdata_out(mem_rdata_in));

	// Keep the last write so checks need not hit its one cycle
	always @(posedge clk_in) begin
		if (mem_wr_out) begin
			wr_addr <= mem_addr_out;
			wr_data <= mem_wdata_out;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Offer one instruction, then time it to done or refusal
	task automatic exec(input logic pre, input logic [7:0] op,
		input logic [7:0] hi, input logic [7:0] lo, input int ncyc);
		int n;
		n = 0;
		@(negedge clk_in);
		while (ready_out !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_in);
		end
		prefix_in = pre;
		opcode_in = op;
		opr_hi_in = hi;
		opr_lo_in = lo;
		valid_in = 1'b1;
		@(negedge clk_in);
		valid_in = 1'b0;
		chk(ready_out, ncyc == 1);
		n = 1;
		while (done_out !== 1'b1 && illegal_out !== 1'b1 && n < 50) begin
			n++;
			@(negedge clk_in);
		end
		chk(n[15:0], ncyc[15:0]);
	endtask : exec

	task automatic end_test(input string nm);
		$display("test %s finished", nm);
	endtask : end_test

	// Single place where the run ends
	task automatic wrap_up;
		$display("compares=%0d mismatches=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Whole run is under two hundred cycles; the limit leaves wide margin
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'hff;
		i_mem.mem[8'h00] = 8'h0f;
		i_mem.mem[8'h40] = 8'h81;
		i_mem.mem[8'h05] = 8'h01;
		repeat (16) @(posedge clk_in);
		@(negedge clk_in);
		arst_n_in = 1'b1;
		chk(acc_out, 8'h00);
		chk(sp_out, 16'h00ff);
		chk(flags_out, 8'h68);
		chk(ready_out, 1'b1);
		end_test("reset");
		exec(1'b0, 8'hab, 8'h00, 8'h7f, 2);
		chk(flags_out, 8'h68);
		exec(1'b0, 8'hab, 8'h00, 8'h01, 2);
		chk(acc_out, 8'h80);
		chk(flags_out, 8'hfc);
		exec(1'b0, 8'hab, 8'h00, 8'h80, 2);
		chk(flags_out, 8'heb);
		exec(1'b0, 8'ha4, 8'h00, 8'hff, 2);
		chk(flags_out, 8'h6b);
		exec(1'b0, 8'ha9, 8'h00, 8'h00, 2);
		chk(acc_out, 8'h01);
		exec(1'b0, 8'hfb, 8'h00, 8'h00, 2);
		chk(acc_out, 8'h10);
		chk(flags_out, 8'h78);
		exec(1'b1, 8'he9, 8'h00, 8'h01, 4);
		chk(acc_out, 8'h1f);
		end_test("add");
		exec(1'b0, 8'hab, 8'h00, 8'ha2, 2);
		exec(1'b0, 8'h48, 8'h00, 8'h00, 1);
		chk(acc_out, 8'h82);
		chk(flags_out, 8'h7d);
		exec(1'b0, 8'h47, 8'h00, 8'h00, 1);
		chk(acc_out, 8'hc1);
		chk(flags_out, 8'hfc);
		exec(1'b0, 8'h38, 8'h00, 8'h40, 4);
		chk(wr_addr, 16'h0040);
		chk(wr_data, 8'h02);
		chk(flags_out, 8'hf9);
		exec(1'b0, 8'h67, 8'h00, 8'h05, 4);
		chk(wr_data, 8'h00);
		chk(flags_out, 8'hfb);
		exec(1'b0, 8'h57, 8'h00, 8'h00, 1);
		chk(flags_out, 8'h7a);
		exec(1'b1, 8'h68, 8'h00, 8'h41, 5);
		chk(wr_addr, 16'h0140);
		chk(wr_data, 8'h04);
		end_test("shift");
		// Carry clear here: one taken backward, one untaken
		f_b = flags_out;
		pc_b = pc_out;
		exec(1'b0, 8'h24, 8'h00, 8'hf0, 3);
		chk(pc_out, pc_b + 16'hfff2);
		pc_b = pc_out;
		exec(1'b0, 8'h25, 8'h00, 8'h10, 3);
		chk(pc_out, pc_b + 16'h0002);
		chk(flags_out, f_b);
		exec(1'b0, 8'hab, 8'h00, 8'hff, 2);
		f_b = flags_out;
		pc_b = pc_out;
		exec(1'b0, 8'h25, 8'h00, 8'h7e, 3);
		chk(pc_out, pc_b + 16'h0080);
		pc_b = pc_out;
		exec(1'b0, 8'h24, 8'h00, 8'h7e, 3);
		chk(pc_out, pc_b + 16'h0002);
		chk(flags_out, f_b);
		end_test("branch");
		exec(1'b0, 8'ha7, 8'h00, 8'hfe, 2);
		chk(sp_out, 16'h00fd);
		exec(1'b0, 8'haf, 8'h00, 8'h80, 2);
		chk(hx_out, 16'hff80);
		chk(flags_out, f_b);
		end_test("adjust");
		// Every bit position once, each in its own byte
		for (int k = 0; k < 8; k++) begin
			exec(1'b0, 8'h11 + 8'(2 * k), 8'h00, 8'h20 + 8'(k), 4);
			chk(wr_addr, {8'h00, 8'h20 + 8'(k)});
			chk(wr_data, 8'hff & ~(8'h01 << k));
			chk(flags_out, f_b);
		end
		end_test("bitclear");
		// Remaining addressing modes; indexed sums wrap at 16 bits
		exec(1'b0, 8'h78, 8'h00, 8'h00, 3);
		chk(wr_addr, 16'hff80);
		chk(wr_data, 8'hfe);
		chk(flags_out, 8'h7d);
		exec(1'b0, 8'h77, 8'h00, 8'h00, 3);
		chk(wr_data, 8'hff);
		chk(flags_out, 8'hfc);
		exec(1'b0, 8'hb4, 8'h00, 8'h40, 3);
		chk(acc_out, 8'h00);
		chk(flags_out, 8'h7a);
		exec(1'b0, 8'hcb, 8'h12, 8'h00, 4);
		chk(acc_out, 8'h0f);
		chk(flags_out, 8'h68);
		exec(1'b0, 8'hd9, 8'h00, 8'h81, 4);
		chk(acc_out, 8'h0e);
		chk(flags_out, 8'h79);
		exec(1'b1, 8'hdb, 8'h01, 8'h03, 5);
		chk(acc_out, 8'h1d);
		exec(1'b0, 8'h58, 8'h00, 8'h00, 1);
		chk(hx_out, 16'hff00);
		chk(flags_out, 8'hfb);
		end_test("modes");
		pc_b = pc_out;
		exec(1'b0, 8'h9d, 8'h00, 8'h00, 1);
		chk(illegal_out, 1'b1);
		chk(pc_out, pc_b);
		end_test("illegal");
		wrap_up();
	end
endmodule : test_alu_shift_branch_subset
